// ===== common/host_port_pkg.sv
// Shared constants and types of the multiplexed host port front end
package host_port_pkg;

  // Bus and address widths
  localparam int DATA_W = 8;                     // Host data bus width
  localparam int ADDR_W = 16;                    // Port address register width

  // Access-select encoding {access_sel_1, access_sel_0}
  localparam logic [1:0] SEL_CTRL     = 2'h0;    // Control register
  localparam logic [1:0] SEL_DATA_INC = 2'h1;    // Data register, autoincrement
  localparam logic [1:0] SEL_ADDR     = 2'h2;    // Address register
  localparam logic [1:0] SEL_DATA     = 2'h3;    // Data register, fixed address

  // Reset and idle values
  localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0000; // Address register reset
  localparam logic [DATA_W-1:0] BYTE_RST  = 8'h00;    // Byte register reset
  localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001; // Autoincrement step
  localparam logic              RDY_IDLE  = 1'b1;     // Ready level after reset
  localparam logic              IRQ_IDLE  = 1'b1;     // Interrupt level after reset

  // Byte order inside one host cycle
  localparam logic BYTE_FIRST = 1'b0;            // byte_ident_in low marks first byte
  localparam int   HI_LSB     = 8;               // High byte position in a word

  // Transfer sequencer states
  typedef enum logic [1:0] {
    XS_IDLE,                                     // Waiting for a strobe
    XS_ACTIVE,                                   // Strobe held, access in progress
    XS_WAIT                                      // Waiting for core to answer
  } xfer_state_t;

endpackage : host_port_pkg

// ===== common/host_word_if.sv
// Word carrier between the pin front end and its address unit
interface host_word_if;
  import host_port_pkg::*;
  logic              strobe;                     // One-cycle access pulse
  logic              write;                      // Access is a write
  logic [1:0]        sel;                        // Register target
  logic              second;                     // Second byte of host cycle
  logic [DATA_W-1:0] wbyte;                      // Byte written by host
  logic [ADDR_W-1:0] addr;                       // Current port address

  modport front (output strobe, write, sel, second, wbyte, input addr);
  modport addr_unit (input strobe, write, sel, second, wbyte, output addr);
endinterface : host_word_if

// ===== core/host_port_addr.sv
// Port address register with strobe latch and autoincrement
module host_port_addr
  import host_port_pkg::*;
(
  input  wire logic   clk,                       // Device clock
  input  wire logic   reset_n,                   // Synchronous reset, active low
  input  wire logic   ce,                        // Clock enable
  input  wire logic   as_load,                   // Address strobe latch pulse
  input  wire logic [DATA_W-1:0] as_byte,        // Bus byte at strobe
  input  wire logic   as_second,                 // Strobe on second byte
  host_word_if.addr_unit w                       // Access carrier
);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;                     // Address register
  } st_t;

  st_t st_r;                                     // Registered state
  st_t st_nxt;                                   // Next state

  assign w.addr = st_r.addr;

  // Address updates: strobe latch, direct write, autoincrement
  always_comb begin
    st_nxt = st_r;
    if (as_load) begin                           // Latch from multiplexed bus
      if (as_second)
        st_nxt.addr[ADDR_W-1:HI_LSB] = as_byte;
      else
        st_nxt.addr[HI_LSB-1:0] = as_byte;
    end else if (w.strobe && w.write && w.sel == SEL_ADDR) begin
      if (w.second)
        st_nxt.addr[ADDR_W-1:HI_LSB] = w.wbyte;
      else
        st_nxt.addr[HI_LSB-1:0] = w.wbyte;
    end else if (w.strobe && w.second && w.sel == SEL_DATA_INC) begin
      st_nxt.addr = st_r.addr + ADDR_STEP;       // Step after full word
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n)
      st_r <= '{addr: ADDR_RST};
    else if (ce)
      st_r <= st_nxt;
  end

endmodule : host_port_addr

// ===== core/host_port_pins.sv
// Pin function selection, strap capture and tri-state control
module host_port_pins
  import host_port_pkg::*;
(
  input  wire logic clk,                         // Device clock
  input  wire logic reset_n,                     // Synchronous reset, active low
  input  wire logic ce,                          // Clock enable
  input  wire logic function_strap,              // Pin function strap
  input  wire logic port_enable_in,              // Port enable pin
  output logic      host_mode,                   // Pins act as host port
  output logic      out_live                     // Outputs may drive
);

  typedef struct packed {
    logic strap;                                 // Captured strap
    logic live;                                  // Out of reset
  } st_t;

  st_t st_r;                                     // Registered state
  st_t st_nxt;                                   // Next state

  // Strap tracks the pin while in reset, frozen once released
  always_comb begin
    st_nxt = st_r;
    st_nxt.live = 1'b1;
  end

  // Capture happens on every clock edge while reset is low, so the value held is the last one
  // sampled before reset rose
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r.live  <= 1'b0;
      st_r.strap <= function_strap;              // Clocked sample of strap
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign host_mode = st_r.strap;
  assign out_live  = st_r.live && port_enable_in; // Z in reset or disable

endmodule : host_port_pins

// ===== core/host_port_frontend.sv
// Pin-level front end of the multiplexed 8-bit host port
module host_port_frontend
  import host_port_pkg::*;
(
  input  wire logic              clk,             // Device clock, 200 MHz
  input  wire logic              reset_n,         // Synchronous reset, active low
  input  wire logic              ce,              // Clock enable, freezes state
  input  wire logic              function_strap,  // Pin function strap
  input  wire logic              port_enable_in,  // Port enable pin
  input  wire logic              host_ctrl_pin_a_i, // Pin A input
  output logic                   host_ctrl_pin_a_o, // Pin A output value
  output logic                   host_ctrl_pin_a_oe_n, // Pin A drive, low drives
  input  wire logic              host_ctrl_pin_b_i, // Pin B input
  output logic                   host_ctrl_pin_b_o, // Pin B output value
  output logic                   host_ctrl_pin_b_oe_n, // Pin B drive, low drives
  input  wire logic              access_sel_0,    // Access select bit 0
  input  wire logic              access_sel_1,    // Access select bit 1
  input  wire logic              port_select_n,   // Port select, active low
  input  wire logic              read_write_sel,  // High read, low write
  input  wire logic              data_strobe_1,   // Data strobe 1
  input  wire logic              data_strobe_2,   // Data strobe 2
  input  wire logic [DATA_W-1:0] host_data_bus_i, // Data bus input
  output logic [DATA_W-1:0]      host_data_bus_o, // Data bus output value
  output logic                   host_data_bus_oe_n, // Data bus drive, low drives
  output logic                   port_ready_out,  // Ready value
  output logic                   port_ready_oe_n, // Ready drive, low drives
  output logic                   host_irq_out,    // Host interrupt value
  output logic                   host_irq_oe_n,   // Interrupt drive, low drives
  input  wire logic              gp_dir_a,        // Core: gp bit A is output
  input  wire logic              gp_out_a,        // Core: gp bit A value
  input  wire logic              gp_dir_b,        // Core: gp bit B is output
  input  wire logic              gp_out_b,        // Core: gp bit B value
  output logic                   gp_io_bit_a,     // Gp bit A level to core
  output logic                   gp_io_bit_b,     // Gp bit B level to core
  input  wire logic              irq_req,         // Core asks to interrupt host
  input  wire logic              irq_ack,         // Core clears host interrupt
  input  wire logic              core_busy,       // Core cannot take access yet
  input  wire logic [DATA_W-1:0] ctrl_rdata,      // Control register low byte
  input  wire logic [ADDR_W-1:0] data_rdata,      // Data word at current address
  output logic                   acc_valid,       // One-cycle access pulse
  output logic                   acc_write,       // Access is a write
  output logic [1:0]             acc_sel,         // Register target
  output logic                   acc_second,      // Second byte of the word
  output logic [DATA_W-1:0]      acc_wbyte,       // Byte written by host
  output logic [ADDR_W-1:0]      port_address_reg // Current port address
);

  logic host_mode;                               // Pins act as host port
  logic out_live;                                // Outputs may drive
  logic strobe_in;                               // Combined strobe level
  logic as_load;                                 // Address strobe latch pulse
  logic byte_sel;                                // Byte ident while host mode

  host_word_if w ();                             // Carrier to address unit

  typedef struct packed {
    xfer_state_t       state;                    // Transfer sequencer
    logic              as_prev;                  // Address strobe last cycle
    logic              irq;                      // Interrupt level, low asserts
    logic              drive;                    // Host read in progress
    logic [DATA_W-1:0] rbyte;                    // Read byte register
    logic              pulse;                    // Access pulse
    logic              write;                    // Access write flag
    logic [1:0]        sel;                      // Access target
    logic              second;                   // Access byte flag
    logic [DATA_W-1:0] wbyte;                    // Access write byte
  } st_t;

  st_t st_r;                                     // Registered state
  st_t st_nxt;                                   // Next state

  // Pin function and output gating
  host_port_pins u_pins (
    .clk            (clk),
    .reset_n        (reset_n),
    .ce             (ce),
    .function_strap (function_strap),
    .port_enable_in (port_enable_in),
    .host_mode      (host_mode),
    .out_live       (out_live)
  );

  // Address register
  host_port_addr u_addr (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .as_load   (as_load),
    .as_byte   (host_data_bus_i),
    .as_second (byte_sel),
    .w         (w)
  );

  // Strobes combine: transfer active when exactly one strobe is low
  assign strobe_in = data_strobe_1 ^ data_strobe_2;
  assign byte_sel  = host_mode ? host_ctrl_pin_b_i : BYTE_FIRST;
  // Falling edge of address strobe, only in multiplexed host mode
  assign as_load   = host_mode && out_live && !port_select_n
                     && st_r.as_prev && !host_ctrl_pin_a_i;

  // Gp bits see the pins in both pin functions, host or gp
  assign gp_io_bit_a = host_ctrl_pin_a_i;
  assign gp_io_bit_b = host_ctrl_pin_b_i;

  // Sequencer and output registers
  always_comb begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    st_nxt.as_prev = host_ctrl_pin_a_i;
    if (irq_req)
      st_nxt.irq = ~IRQ_IDLE;                    // Assert toward host
    else if (irq_ack)
      st_nxt.irq = IRQ_IDLE;
    unique case (st_r.state)
      XS_IDLE: begin
        // Access taken only in host mode, while selected
        if (host_mode && out_live && !port_select_n && strobe_in) begin
          st_nxt.state  = XS_ACTIVE;
          st_nxt.pulse  = 1'b1;
          st_nxt.write  = !read_write_sel;
          st_nxt.sel    = {access_sel_1, access_sel_0};
          st_nxt.second = byte_sel;
          st_nxt.wbyte  = host_data_bus_i;
          st_nxt.drive  = read_write_sel;        // Drive bus on read
          unique case ({access_sel_1, access_sel_0})
            SEL_CTRL:
              st_nxt.rbyte = ctrl_rdata;
            SEL_ADDR:
              st_nxt.rbyte = byte_sel ? w.addr[ADDR_W-1:HI_LSB] : w.addr[HI_LSB-1:0];
            SEL_DATA, SEL_DATA_INC:
              st_nxt.rbyte = byte_sel ? data_rdata[ADDR_W-1:HI_LSB] : data_rdata[HI_LSB-1:0];
          endcase
        end
      end
      XS_ACTIVE: begin
        if (!strobe_in) begin
          st_nxt.drive = 1'b0;
          st_nxt.state = core_busy ? XS_WAIT : XS_IDLE;
        end
      end
      XS_WAIT: begin
        if (!core_busy)                          // Ready returns once core done
          st_nxt.state = XS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '{state: XS_IDLE, as_prev: 1'b1, irq: IRQ_IDLE, drive: 1'b0,
                rbyte: BYTE_RST, pulse: 1'b0, write: 1'b0, sel: SEL_CTRL,
                second: BYTE_FIRST, wbyte: BYTE_RST};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Carrier toward address unit
  assign w.strobe = st_r.pulse;
  assign w.write  = st_r.write;
  assign w.sel    = st_r.sel;
  assign w.second = st_r.second;
  assign w.wbyte  = st_r.wbyte;

  // Access report to core
  assign acc_valid        = st_r.pulse;
  assign acc_write        = st_r.write;
  assign acc_sel          = st_r.sel;
  assign acc_second       = st_r.second;
  assign acc_wbyte        = st_r.wbyte;
  assign port_address_reg = w.addr;

  // Host outputs, undriven in reset or when disabled
  assign port_ready_out     = (st_r.state == XS_IDLE) ? RDY_IDLE : ~RDY_IDLE;
  assign port_ready_oe_n    = !(out_live && host_mode);
  assign host_irq_out       = st_r.irq;
  assign host_irq_oe_n      = !(out_live && host_mode);
  assign host_data_bus_o    = st_r.rbyte;
  assign host_data_bus_oe_n = !(out_live && host_mode && st_r.drive);

  // Shared pins are inputs in host mode; gp outputs only after core asks
  assign host_ctrl_pin_a_o    = gp_out_a;
  assign host_ctrl_pin_a_oe_n = !(out_live && !host_mode && gp_dir_a);
  assign host_ctrl_pin_b_o    = gp_out_b;
  assign host_ctrl_pin_b_oe_n = !(out_live && !host_mode && gp_dir_b);

endmodule : host_port_frontend

// ===== verification/host_port_frontend_assertions.sv
// Pin-level checks of the host port front end, bound to its top module
module host_port_frontend_assertions
  import host_port_pkg::*;
(
  input wire logic       clk,                // Clock
  input wire logic       reset_n,            // Reset, active low
  input wire logic       port_enable_in,     // Port enable
  input wire logic       port_select_n,      // Select, active low
  input wire logic       read_write_sel,     // High read
  input wire logic       access_sel_0,       // Select bit 0
  input wire logic       access_sel_1,       // Select bit 1
  input wire logic       data_strobe_1,      // Strobe 1
  input wire logic       data_strobe_2,      // Strobe 2
  input wire logic       host_ctrl_pin_b_i,  // Byte ident level
  input wire logic       host_data_bus_oe_n, // Bus drive
  input wire logic       port_ready_out,     // Ready value
  input wire logic       port_ready_oe_n,    // Ready drive
  input wire logic       host_irq_out,       // Interrupt value
  input wire logic       host_irq_oe_n,      // Interrupt drive
  input wire logic       irq_req,            // Core sets interrupt
  input wire logic       irq_ack,            // Core clears interrupt
  input wire logic       core_busy,          // Core stall
  input wire logic       acc_valid,          // Access pulse
  input wire logic       acc_write,          // Write access
  input wire logic [1:0] acc_sel,            // Target
  input wire logic       acc_second          // Second byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Access accepted: idle, driving, selected, strobes differ
  sequence s_taken;
    port_enable_in && !port_ready_oe_n && port_ready_out && !port_select_n && (data_strobe_1 != data_strobe_2);
  endsequence
  // Answer: one pulse with ready low
  sequence s_answer;
    acc_valid && !port_ready_out ##1 !acc_valid;
  endsequence
  property p_reset_z; disable iff (1'b0) !reset_n |=> port_ready_oe_n && host_irq_oe_n && host_data_bus_oe_n; endproperty
  property p_disable_z; !port_enable_in |-> port_ready_oe_n && host_irq_oe_n && host_data_bus_oe_n; endproperty
  property p_ignore; port_select_n || !port_enable_in |=> !acc_valid; endproperty
  property p_answer; s_taken |=> s_answer; endproperty
  property p_fields;
    s_taken |=> acc_write == !$past(read_write_sel) && acc_sel == $past({access_sel_1, access_sel_0})
      && acc_second == $past(host_ctrl_pin_b_i);
  endproperty
  property p_ready_back;
    !port_ready_out && !port_ready_oe_n && data_strobe_1 == data_strobe_2 && !core_busy |=> port_ready_out;
  endproperty
  property p_irq_set; irq_req |=> !host_irq_out; endproperty
  property p_irq_clr; irq_ack && !irq_req |=> host_irq_out; endproperty
  a_reset_z: assert property (p_reset_z) else $error("outputs driven in reset");
  a_disable_z: assert property (p_disable_z) else $error("outputs driven while disabled");
  a_ignore: assert property (p_ignore) else $error("access taken while deselected");
  a_answer: assert property (p_answer) else $error("access pulse or ready wrong");
  a_fields: assert property (p_fields) else $error("access fields wrong");
  a_ready_back: assert property (p_ready_back) else $error("ready not restored");
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
endmodule : host_port_frontend_assertions

bind host_port_frontend host_port_frontend_assertions chk (
  .clk(clk), .reset_n(reset_n), .port_enable_in(port_enable_in), .port_select_n(port_select_n),
  .read_write_sel(read_write_sel), .access_sel_0(access_sel_0), .access_sel_1(access_sel_1),
  .data_strobe_1(data_strobe_1), .data_strobe_2(data_strobe_2), .host_ctrl_pin_b_i(host_ctrl_pin_b_i),
  .host_data_bus_oe_n(host_data_bus_oe_n), .port_ready_out(port_ready_out), .port_ready_oe_n(port_ready_oe_n),
  .host_irq_out(host_irq_out), .host_irq_oe_n(host_irq_oe_n), .irq_req(irq_req), .irq_ack(irq_ack),
  .core_busy(core_busy), .acc_valid(acc_valid), .acc_write(acc_write), .acc_sel(acc_sel), .acc_second(acc_second)
);

// ===== verification/host_port_host_model.sv
// Behavioural host driving the multiplexed byte bus
module host_port_host_model
  import host_port_pkg::*;
(
  input  wire logic              clk,    // Clock
  input  wire logic              rdy,    // Ready as seen on the wire
  input  wire logic [DATA_W-1:0] bus,    // Resolved bus
  output logic                   cs_n,   // Select, active low
  output logic                   rd,     // High read
  output logic [1:0]             sel,    // Access select
  output logic                   stb1,   // Strobe 1
  output logic                   stb2,   // Strobe 2
  output logic                   as_pin, // Address strobe
  output logic                   ident,  // Byte ident
  output logic                   drv,    // Host drives bus
  output logic [DATA_W-1:0]      wd      // Host byte
);
  // Idle levels
  initial begin
    cs_n = 1'b1;
    rd = 1'b1;
    sel = 2'h0;
    stb1 = 1'b1;
    stb2 = 1'b1;
    as_pin = 1'b1;
    ident = 1'b0;
    drv = 1'b0;
    wd = 8'h00;
  end
  // One byte transfer, then wait for ready
  task automatic xfer(input logic c, input logic [1:0] s, input logic r, input logic id,
                      input logic [DATA_W-1:0] b, output logic [DATA_W-1:0] q);
    int n;
    @(posedge clk);
    cs_n <= c;
    rd <= r;
    sel <= s;
    ident <= id;
    wd <= b;
    drv <= !r;
    @(posedge clk);
    if (r) stb2 <= 1'b0;
    else stb1 <= 1'b0;
    repeat (3) @(posedge clk);
    q = bus;
    stb1 <= 1'b1;
    stb2 <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 64);
    cs_n <= 1'b1;
    drv <= 1'b0;
  endtask : xfer
  // Address byte latched by a strobe pulse
  task automatic latch(input logic id, input logic [DATA_W-1:0] b);
    @(posedge clk);
    cs_n <= 1'b0;
    ident <= id;
    wd <= b;
    drv <= 1'b1;
    @(posedge clk);
    as_pin <= 1'b0;
    repeat (2) @(posedge clk);
    as_pin <= 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
    drv <= 1'b0;
  endtask : latch
endmodule : host_port_host_model

// ===== verification/host_port_frontend_tb.sv
// Self-checking testbench of the host port pin front end
module host_port_frontend_tb
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset_n = 1'b0, function_strap = 1'b1, port_enable_in = 1'b1; // Clock, straps
  logic gp_dir_a = 1'b0, gp_out_a = 1'b0, gp_dir_b = 1'b0, gp_out_b = 1'b0;   // Core gp controls
  logic irq_req = 1'b0, irq_ack = 1'b0, core_busy = 1'b0;                      // Core levels
  logic [DATA_W-1:0] ctrl_rdata = 8'h5a, bus_byte, bus_i, bus_o, byte_rd, acc_wbyte; // Bytes
  logic [ADDR_W-1:0] data_rdata = 16'hc3a7, port_address_reg;                  // Words
  logic pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n, pin_a_i, pin_b_i, rdy_seen;  // Pins
  logic port_select_n, read_write_sel, data_strobe_1, data_strobe_2, addr_strobe, byte_ident, bus_drive;
  logic bus_oe_n, port_ready_out, port_ready_oe_n, host_irq_out, host_irq_oe_n;
  logic acc_valid, acc_write, acc_second, gp_io_bit_a, gp_io_bit_b;
  logic [1:0] access_sel, acc_sel;
  int mismatches = 0, check_count = 0, pulses = 0, cycles = 0;
  // Wire levels; an undriven bus shows the inverse of the host byte, an undriven ready reads low
  assign pin_a_i = !pin_a_oe_n ? pin_a_o : addr_strobe;
  assign pin_b_i = !pin_b_oe_n ? pin_b_o : byte_ident;
  assign bus_i = !bus_oe_n ? bus_o : (bus_drive ? bus_byte : ~bus_byte);
  assign rdy_seen = port_ready_oe_n ? 1'b0 : port_ready_out;
  always #2.5 clk = ~clk;
  host_port_frontend uut (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .function_strap(function_strap), .port_enable_in(port_enable_in),
    .host_ctrl_pin_a_i(pin_a_i), .host_ctrl_pin_a_o(pin_a_o), .host_ctrl_pin_a_oe_n(pin_a_oe_n),
    .host_ctrl_pin_b_i(pin_b_i), .host_ctrl_pin_b_o(pin_b_o), .host_ctrl_pin_b_oe_n(pin_b_oe_n),
    .access_sel_0(access_sel[0]), .access_sel_1(access_sel[1]), .port_select_n(port_select_n),
    .read_write_sel(read_write_sel), .data_strobe_1(data_strobe_1), .data_strobe_2(data_strobe_2),
    .host_data_bus_i(bus_i), .host_data_bus_o(bus_o), .host_data_bus_oe_n(bus_oe_n),
    .port_ready_out(port_ready_out), .port_ready_oe_n(port_ready_oe_n), .host_irq_out(host_irq_out),
    .host_irq_oe_n(host_irq_oe_n), .gp_dir_a(gp_dir_a), .gp_out_a(gp_out_a), .gp_dir_b(gp_dir_b),
    .gp_out_b(gp_out_b), .gp_io_bit_a(gp_io_bit_a), .gp_io_bit_b(gp_io_bit_b), .irq_req(irq_req),
    .irq_ack(irq_ack), .core_busy(core_busy), .ctrl_rdata(ctrl_rdata), .data_rdata(data_rdata),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_sel(acc_sel), .acc_second(acc_second),
    .acc_wbyte(acc_wbyte), .port_address_reg(port_address_reg));
  host_port_host_model host (.clk(clk), .rdy(rdy_seen), .bus(bus_i), .cs_n(port_select_n), .rd(read_write_sel),
    .sel(access_sel), .stb1(data_strobe_1), .stb2(data_strobe_2), .as_pin(addr_strobe), .ident(byte_ident),
    .drv(bus_drive), .wd(bus_byte));
  // Pulse counter and cycle ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (acc_valid === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Reset with a strap level that flips once released
  task automatic do_reset(input logic strap);
    @(posedge clk);
    reset_n <= 1'b0;
    function_strap <= strap;
    repeat (8) @(posedge clk);
    check_word("oe_n in reset", 16'h0003, {14'h0000, port_ready_oe_n, host_irq_oe_n});
    reset_n <= 1'b1;
    function_strap <= !strap;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic t_host_mode();
    check_word("ready irq levels", 16'h0003, {14'h0000, port_ready_out, host_irq_out});
    check_word("oe_n after reset", 16'h0007, {11'h000, port_ready_oe_n, host_irq_oe_n, pin_a_oe_n, pin_b_oe_n,
      bus_oe_n});
  endtask : t_host_mode
  task automatic t_sel_table();
    logic [1:0] s;
    int p;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      p = pulses;
      host.xfer(1'b0, s, 1'b0, s[0], 8'h50 + 8'(i), byte_rd);
      check_word("pulses", 16'h0001, 16'(pulses - p));
      check_word("fields", {4'h0, 1'b1, s, s[0], 8'h50 + 8'(i)}, {4'h0, acc_write, acc_sel, acc_second,
        acc_wbyte});
    end
  endtask : t_sel_table
  task automatic t_reads();
    host.xfer(1'b0, SEL_CTRL, 1'b1, 1'b0, 8'h00, byte_rd);
    check_word("ctrl read", {8'h00, ctrl_rdata}, {8'h00, byte_rd});
    host.xfer(1'b0, SEL_DATA, 1'b1, 1'b0, 8'h00, byte_rd);
    check_word("low byte", {8'h00, data_rdata[7:0]}, {8'h00, byte_rd});
    host.xfer(1'b0, SEL_DATA, 1'b1, 1'b1, 8'h00, byte_rd);
    check_word("high byte", {8'h00, data_rdata[15:8]}, {8'h00, byte_rd});
  endtask : t_reads
  task automatic t_addr();
    host.latch(1'b0, 8'hff);
    host.latch(1'b1, 8'h12);
    check_word("latched addr", 16'h12ff, port_address_reg);
    host.xfer(1'b0, SEL_DATA_INC, 1'b0, 1'b0, 8'h11, byte_rd);
    host.xfer(1'b0, SEL_DATA_INC, 1'b0, 1'b1, 8'h22, byte_rd);
    check_word("autoinc addr", 16'h1300, port_address_reg);
    host.xfer(1'b0, SEL_DATA, 1'b0, 1'b1, 8'h33, byte_rd);
    check_word("fixed addr", 16'h1300, port_address_reg);
  endtask : t_addr
  task automatic t_refuse();
    int p;
    p = pulses;
    host.xfer(1'b1, SEL_CTRL, 1'b0, 1'b0, 8'h44, byte_rd);
    port_enable_in <= 1'b0;
    repeat (2) @(posedge clk);
    check_word("oe_n disabled", 16'h0007, {13'h0000, port_ready_oe_n, host_irq_oe_n, bus_oe_n});
    host.xfer(1'b0, SEL_CTRL, 1'b1, 1'b0, 8'h00, byte_rd);
    check_word("refused pulses", 16'h0000, 16'(pulses - p));
    port_enable_in <= 1'b1;
  endtask : t_refuse
  task automatic t_busy();
    core_busy <= 1'b1;
    fork
      host.xfer(1'b0, SEL_DATA, 1'b0, 1'b0, 8'h66, byte_rd);
      begin
        repeat (12) @(posedge clk);
        check_word("ready while busy", 16'h0000, {15'h0000, port_ready_out});
        core_busy <= 1'b0;
      end
    join
    check_word("ready after busy", 16'h0001, {15'h0000, port_ready_out});
  endtask : t_busy
  task automatic t_irq();
    irq_req <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_req <= 1'b0;
    irq_ack <= 1'b0;
    repeat (2) @(posedge clk);
    check_word("irq set wins", 16'h0000, {15'h0000, host_irq_out});
    irq_ack <= 1'b1;
    repeat (2) @(posedge clk);
    irq_ack <= 1'b0;
    check_word("irq cleared", 16'h0001, {15'h0000, host_irq_out});
  endtask : t_irq
  task automatic t_gp_mode();
    do_reset(1'b0);
    check_word("gp oe_n", 16'h0007, {13'h0000, port_ready_oe_n, pin_a_oe_n, pin_b_oe_n});
    gp_dir_a <= 1'b1;
    gp_out_a <= 1'b1;
    gp_dir_b <= 1'b1;
    repeat (3) @(posedge clk);
    check_word("gp drive", 16'h0005, {12'h000, pin_a_oe_n, pin_a_o, pin_b_oe_n, gp_io_bit_a ^ gp_io_bit_b});
    gp_dir_a <= 1'b0;
    gp_dir_b <= 1'b0;
    host.latch(1'b0, 8'h77);
    check_word("strobe ignored", ADDR_RST, port_address_reg);
  endtask : t_gp_mode
  // Main sequence
  initial begin
    do_reset(1'b1);
    t_host_mode();
    t_sel_table();
    t_reads();
    t_addr();
    t_refuse();
    t_busy();
    t_irq();
    t_gp_mode();
    print_verdict();
  end
endmodule : host_port_frontend_tb
